/* File: gdfp_map.vh */
// constants for the gate driver fault protection block
// included by gdfp_top.v, gdfp_stretch.v does not include it
`ifndef GDFP_MAP_VH
`define GDFP_MAP_VH
`define GDFP_CLK_HZ 10000000
`define GDFP_STRETCH_US 64
`define GDFP_STRETCH_CYC ((`GDFP_STRETCH_US * `GDFP_CLK_HZ) / 1000000)
`define GDFP_EN_LOW_US 10
`define GDFP_EN_LOW_CYC ((`GDFP_EN_LOW_US * `GDFP_CLK_HZ) / 1000000)
`define GDFP_DT_MIN_NS 50
`define GDFP_DT_MAX_NS 500
`define GDFP_DT_MIN_CYC ((`GDFP_DT_MIN_NS * (`GDFP_CLK_HZ / 1000000) + 999) / 1000)
`define GDFP_DT_MAX_CYC ((`GDFP_DT_MAX_NS * (`GDFP_CLK_HZ / 1000000)) / 1000)
`define GDFP_ADDR_STATUS1 2'h0
`define GDFP_ADDR_STATUS2 2'h1
`define GDFP_ADDR_CTRL1 2'h2
`define GDFP_ADDR_CTRL2 2'h3
`define GDFP_CTRL1_RESET 32'h00000000
`define GDFP_CTRL2_RESET 32'h00000000
`define GDFP_C1_RESET_BIT 2
`define GDFP_C1_OCM_LO 4
`define GDFP_C1_OCM_HI 5
`define GDFP_C2_WARN_LO 0
`define GDFP_C2_WARN_HI 1
`define GDFP_C2_DT_LO 4
`define GDFP_C2_DT_HI 7
`define GDFP_OCM_LIMIT 2'h0
`define GDFP_OCM_LATCH 2'h1
`define GDFP_OCM_REPORT 2'h2
`define GDFP_OCM_OFF 2'h3
`define GDFP_WARN_BOTH 2'h0
`define GDFP_WARN_OT 2'h1
`define GDFP_WARN_OC 2'h2
`define GDFP_DEVICE_ID 4'h0
`endif

/* File: gdfp_stretch.v */
// retriggerable pulse stretcher, output high for LEN cycles after last trigger
// assumes trigger and clear from logic on the same clock
`timescale 1ns/1ps
module gdfp_stretch #(
  parameter LEN = 640
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // control
  input wire trig,
  input wire cut,
  output wire active
);
  reg [15:0] cnt_reg;
  assign active = (cnt_reg != 16'h0000);
  always @(posedge clk) begin
    if (!nrst) begin
      cnt_reg <= 16'h0000;
    end else if (trig) begin
      cnt_reg <= LEN[15:0];
    end else if (cut) begin
      cnt_reg <= 16'h0000;
    end else if (active) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end
endmodule

/* File: gdfp_top.v */
// fault protection, enable sequencing and dead time for a 3-phase pre-driver
// assumes analog comparators and enable pin are asynchronous, Avalon-MM master on clk
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "gdfp_map.vh"
module gdfp_top #(
  parameter STRETCH_CYC = `GDFP_STRETCH_CYC,
  parameter EN_LOW_CYC = `GDFP_EN_LOW_CYC
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // avalon-mm slave
  input wire [1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  // enable pin and analog monitors, asynchronous
  input wire en_gate_pin,
  input wire power_rail_undervoltage,
  input wire drive_supply_undervoltage,
  input wire drive_supply_overvoltage,
  input wire logic_supply_undervoltage,
  input wire thermal_warning,
  input wire thermal_shutdown_driver,
  input wire [5:0] oc_detect,
  // pwm inputs, same clock, {ha,la,hb,lb,hc,lc}
  input wire [5:0] pwm_in,
  // gate outputs
  output wire [5:0] gate_out,
  // block enables
  output wire charge_pump_en,
  output wire regulator_en,
  // open-drain fault, enable low while driving low
  output wire fault_out_o,
  output wire fault_out_oe_n,
  // warning pin, active low, open-drain
  output wire warning_out_pin_o,
  output wire warning_out_pin_oe_n
);
  // two-flop synchronisers
  reg [13:0] sync1_reg;
  reg [13:0] sync2_reg;
  wire [13:0] async_in = {oc_detect, en_gate_pin, power_rail_undervoltage,
    drive_supply_undervoltage, drive_supply_overvoltage, logic_supply_undervoltage,
    thermal_warning, thermal_shutdown_driver, 1'b0};
  always @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= 14'h0000;
      sync2_reg <= 14'h0000;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end
  wire [5:0] oc_s = sync2_reg[13:8];
  wire en_s = sync2_reg[7];
  wire prail_uv = sync2_reg[6];
  wire dsup_uv = sync2_reg[5];
  wire dsup_ov = sync2_reg[4];
  wire lsup_uv = sync2_reg[3];
  wire ot_warn = sync2_reg[2];
  wire ot_sd = sync2_reg[1];

  // registers
  reg [31:0] ctrl1_reg;
  reg [31:0] ctrl2_reg;
  reg [10:0] stat1_reg;
  reg stat2_ov_reg;
  reg [31:0] rdata_reg;
  reg rd_done_reg;
  wire [1:0] ocm = ctrl1_reg[`GDFP_C1_OCM_HI:`GDFP_C1_OCM_LO];
  wire [1:0] warn_sel = ctrl2_reg[`GDFP_C2_WARN_HI:`GDFP_C2_WARN_LO];
  wire [3:0] dt_set = ctrl2_reg[`GDFP_C2_DT_HI:`GDFP_C2_DT_LO];
  wire wr_ctrl1 = avs_write && (avs_address == `GDFP_ADDR_CTRL1);
  // avalon reset command, self-clearing pulse
  wire cmd_reset = wr_ctrl1 && avs_writedata[`GDFP_C1_RESET_BIT];

  // enable sequencing
  reg en_d_reg;
  reg [15:0] low_cnt_reg;
  reg long_low_reg;
  reg gate_en_reg;
  reg lsup_uv_d_reg;
  reg ov_latch_reg;
  reg otsd_latch_reg;
  wire en_rise = en_s && !en_d_reg;
  wire en_fall = !en_s && en_d_reg;
  always @(posedge clk) begin
    if (!nrst) begin
      en_d_reg <= 1'b0;
      low_cnt_reg <= 16'h0000;
      long_low_reg <= 1'b1;
      gate_en_reg <= 1'b0;
      lsup_uv_d_reg <= 1'b0;
    end else begin
      en_d_reg <= en_s;
      lsup_uv_d_reg <= lsup_uv;
      gate_en_reg <= en_s;
      if (en_s) begin
        low_cnt_reg <= 16'h0000;
        long_low_reg <= 1'b0;
      end else if (low_cnt_reg >= EN_LOW_CYC[15:0]) begin
        long_low_reg <= 1'b1;
      end else begin
        low_cnt_reg <= low_cnt_reg + 16'h0001;
      end
    end
  end
  // pulses shorter than the limit keep pump and regulator running
  assign charge_pump_en = !long_low_reg && !ov_latch_reg && !otsd_latch_reg;
  assign regulator_en = !long_low_reg;
  wire en_rise_long = en_rise && long_low_reg;
  wire lsup_recover = lsup_uv_d_reg && !lsup_uv;
  wire drv_clear = en_rise || cmd_reset;
  wire stat_clear = drv_clear || lsup_recover;

  // latched faults
  reg [2:0] phase_latch_reg;
  wire [2:0] phase_oc = {oc_s[5] | oc_s[4], oc_s[3] | oc_s[2], oc_s[1] | oc_s[0]};
  wire oc_on = (ocm != `GDFP_OCM_OFF);
  always @(posedge clk) begin
    if (!nrst) begin
      ov_latch_reg <= 1'b0;
      otsd_latch_reg <= 1'b0;
      phase_latch_reg <= 3'h0;
    end else begin
      // set wins over clear, present faults persist
      if (dsup_ov) begin
        ov_latch_reg <= 1'b1;
      end else if (en_rise_long) begin
        ov_latch_reg <= 1'b0;
      end
      if (ot_sd) begin
        otsd_latch_reg <= 1'b1;
      end else if (drv_clear) begin
        otsd_latch_reg <= 1'b0;
      end
      if (ocm == `GDFP_OCM_LATCH) begin
        phase_latch_reg <= (drv_clear ? 3'h0 : phase_latch_reg) | phase_oc;
      end else if (drv_clear) begin
        phase_latch_reg <= 3'h0;
      end
    end
  end

  // current limit: detecting fet off until its pwm toggles low
  reg [5:0] lim_off_reg;
  reg [5:0] pwm_d_reg;
  wire lim_mode = (ocm == `GDFP_OCM_LIMIT);
  always @(posedge clk) begin
    if (!nrst) begin
      lim_off_reg <= 6'h00;
      pwm_d_reg <= 6'h00;
    end else begin
      pwm_d_reg <= pwm_in;
      lim_off_reg <= lim_mode ? ((lim_off_reg & pwm_in) | (oc_s & pwm_in)) : 6'h00;
    end
  end

  // shutdown and gate gating
  wire uv_any = prail_uv || dsup_uv || lsup_uv;
  wire shutdown = uv_any || ov_latch_reg || otsd_latch_reg || !gate_en_reg;
  wire [5:0] phase_kill = {{2{phase_latch_reg[2]}}, {2{phase_latch_reg[1]}},
    {2{phase_latch_reg[0]}}};
  // report-only and disabled modes never touch pwm
  wire [5:0] pwm_ok = shutdown ? 6'h00 : (pwm_in & ~phase_kill & ~lim_off_reg);
  reg [31:0] dt_ns;
  reg [31:0] dt_full;
  reg [7:0] dt_cyc;
  always @* begin
    dt_ns = `GDFP_DT_MIN_NS + ((`GDFP_DT_MAX_NS - `GDFP_DT_MIN_NS) * dt_set) / 15;
    dt_full = ((dt_ns * (`GDFP_CLK_HZ / 1000000)) + 999) / 1000;
    dt_cyc = dt_full[7:0];
  end
  reg [5:0] gate_reg;
  reg [7:0] dt_cnt_reg [0:2];
  integer p;
  always @(posedge clk) begin
    if (!nrst) begin
      gate_reg <= 6'h00;
      for (p = 0; p < 3; p = p + 1) begin
        dt_cnt_reg[p] <= 8'h00;
      end
    end else begin
      for (p = 0; p < 3; p = p + 1) begin
        if (pwm_ok[2*p+1] && pwm_ok[2*p]) begin
          gate_reg[2*p+1] <= 1'b0;
          gate_reg[2*p] <= 1'b0;
        end else if ((pwm_ok[2*p+1] && !gate_reg[2*p+1]) || (pwm_ok[2*p] && !gate_reg[2*p])) begin
          gate_reg[2*p+1] <= 1'b0;
          gate_reg[2*p] <= 1'b0;
          if (gate_reg[2*p+1] || gate_reg[2*p]) begin
            dt_cnt_reg[p] <= dt_cyc;
          end else if (dt_cnt_reg[p] > 8'h01) begin
            dt_cnt_reg[p] <= dt_cnt_reg[p] - 8'h01;
          end else begin
            gate_reg[2*p+1] <= pwm_ok[2*p+1];
            gate_reg[2*p] <= pwm_ok[2*p];
            dt_cnt_reg[p] <= dt_cyc;
          end
        end else begin
          gate_reg[2*p+1] <= pwm_ok[2*p+1];
          gate_reg[2*p] <= pwm_ok[2*p];
          dt_cnt_reg[p] <= dt_cyc;
        end
      end
    end
  end
  assign gate_out = gate_reg;

  // warning pin stretch
  wire oc_rep = oc_on && (|oc_s);
  wire lim_cut = lim_mode && ((pwm_d_reg & ~pwm_in) != 6'h00) && !oc_rep;
  wire oc_hold;
  gdfp_stretch #(
    .LEN(STRETCH_CYC)
  ) u_stretch (
    .clk(clk),
    .nrst(nrst),
    .trig(oc_rep),
    .cut(lim_cut),
    .active(oc_hold)
  );
  wire warn_oc = (oc_hold || oc_rep) && (warn_sel != `GDFP_WARN_OT);
  wire warn_ot = (ot_warn || otsd_latch_reg) && (warn_sel != `GDFP_WARN_OC);
  reg warn_reg;
  reg fault_reg;
  always @(posedge clk) begin
    if (!nrst) begin
      warn_reg <= 1'b0;
      fault_reg <= 1'b1;
    end else begin
      warn_reg <= warn_oc || warn_ot;
      fault_reg <= uv_any || ov_latch_reg || otsd_latch_reg || (|phase_latch_reg)
        || !gate_en_reg;
    end
  end
  assign warning_out_pin_o = 1'b0;
  assign warning_out_pin_oe_n = !warn_reg;
  assign fault_out_o = 1'b0;
  assign fault_out_oe_n = !fault_reg;

  // status capture
  wire rd_s1 = avs_read && !rd_done_reg && (avs_address == `GDFP_ADDR_STATUS1);
  wire rd_s2 = avs_read && !rd_done_reg && (avs_address == `GDFP_ADDR_STATUS2);
  // logic supply dips never reach the status bits
  wire fault_stat = fault_reg && !lsup_uv && !lsup_uv_d_reg;
  wire [10:0] stat1_set = {fault_stat, dsup_uv, prail_uv, otsd_latch_reg, ot_warn,
    oc_on ? oc_s : 6'h00};
  always @(posedge clk) begin
    if (!nrst) begin
      stat1_reg <= 11'h000;
      stat2_ov_reg <= 1'b0;
    end else begin
      // set wins over read clear
      stat1_reg <= ((rd_s1 || stat_clear) ? 11'h000 : stat1_reg) | stat1_set;
      stat2_ov_reg <= ((rd_s2 || stat_clear) ? 1'b0 : stat2_ov_reg) | ov_latch_reg;
    end
  end

  // avalon slave, one wait state on read, writes at once
  always @(posedge clk) begin
    if (!nrst) begin
      ctrl1_reg <= `GDFP_CTRL1_RESET;
      ctrl2_reg <= `GDFP_CTRL2_RESET;
      rdata_reg <= 32'h00000000;
      rd_done_reg <= 1'b0;
    end else begin
      // registers survive thermal shutdown
      if (wr_ctrl1) begin
        ctrl1_reg <= {21'h000000, avs_writedata[10:3], 1'b0, avs_writedata[1:0]};
      end
      if (avs_write && (avs_address == `GDFP_ADDR_CTRL2)) begin
        ctrl2_reg <= {21'h000000, avs_writedata[10:0]};
      end
      rd_done_reg <= avs_read && !rd_done_reg;
      if (avs_read && !rd_done_reg) begin
        case (avs_address)
          `GDFP_ADDR_STATUS1: rdata_reg <= {21'h000000, stat1_reg};
          `GDFP_ADDR_STATUS2: rdata_reg <= {24'h000000, stat2_ov_reg, 3'h0, `GDFP_DEVICE_ID};
          `GDFP_ADDR_CTRL1: rdata_reg <= ctrl1_reg;
          `GDFP_ADDR_CTRL2: rdata_reg <= ctrl2_reg;
          default: rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = avs_read && !rd_done_reg;
endmodule

/* File: gdfp_top_assertions.sv */
// checker for the fault protection block
// bound to gdfp_top, sees its ports only
`timescale 1ns/1ps
module gdfp_chk #(
  parameter STRETCH_CYC = 640,
  parameter EN_LOW_CYC = 100
) (
  // clock, reset, bus
  input wire clk, nrst, avs_read, avs_write, avs_waitrequest,
  input wire [1:0] avs_address,
  input wire [31:0] avs_writedata,
  // pins and monitors
  input wire en_gate_pin, power_rail_undervoltage, drive_supply_undervoltage,
  input wire drive_supply_overvoltage, thermal_shutdown_driver,
  input wire [5:0] oc_detect, gate_out,
  input wire charge_pump_en, regulator_en, fault_out_oe_n, warning_out_pin_oe_n
);
  reg [1:0] mode_reg;
  reg [1:0] wsel_reg;
  reg [15:0] low_reg;
  reg [15:0] warn_reg;
  // shadow of mode bits, enable-low and warning-low run lengths
  always @(posedge clk) begin
    if (!nrst) begin
      mode_reg <= 2'h0;
      wsel_reg <= 2'h0;
      low_reg <= 16'h0000;
      warn_reg <= 16'h0000;
    end else begin
      if (avs_write && avs_address == 2'h2) mode_reg <= avs_writedata[5:4];
      if (avs_write && avs_address == 2'h3) wsel_reg <= avs_writedata[1:0];
      low_reg <= en_gate_pin ? 16'h0000 : low_reg + {15'h0000, low_reg != 16'hffff};
      warn_reg <= warning_out_pin_oe_n ? 16'h0000 : warn_reg + {15'h0000, warn_reg != 16'hffff};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_uv_gates_low: assert property ((power_rail_undervoltage || drive_supply_undervoltage) [*4]
    |-> gate_out == 6'h00) else $error("gates driven in undervoltage");
  chk_no_shoot_through: assert property (gate_out[5:4] != 2'h3 && gate_out[3:2] != 2'h3
    && gate_out[1:0] != 2'h3) else $error("both fets of a phase on");
  chk_ov_shutdown: assert property (drive_supply_overvoltage [*5]
    |-> !charge_pump_en && gate_out == 6'h00 && !fault_out_oe_n) else $error("ov not shut");
  chk_ot_shutdown: assert property (thermal_shutdown_driver [*5]
    |-> !charge_pump_en && gate_out == 6'h00 && !fault_out_oe_n) else $error("ot not shut");
  chk_long_low_off: assert property (low_reg > EN_LOW_CYC + 4
    |-> !regulator_en && !charge_pump_en && gate_out == 6'h00) else $error("blocks still on");
  chk_quick_keeps_reg: assert property (!en_gate_pin && low_reg < EN_LOW_CYC && regulator_en
    |=> regulator_en) else $error("regulator dropped in quick reset");
  chk_off_silent: assert property ($fell(warning_out_pin_oe_n)
    |-> !(mode_reg == 2'h3 && wsel_reg == 2'h2)) else $error("warning in oc off mode");
  chk_stretch_len: assert property ($rose(warning_out_pin_oe_n) && mode_reg == 2'h2
    |-> warn_reg >= STRETCH_CYC - 1) else $error("warning stretch too short");
  chk_latch_fault: assert property (mode_reg == 2'h1 && oc_detect != 6'h00
    |-> ##5 !fault_out_oe_n) else $error("latched oc without fault");
  chk_read_answer: assert property (avs_read && avs_waitrequest
    |=> !avs_waitrequest) else $error("read not answered");
endmodule
bind gdfp_top gdfp_chk #(.STRETCH_CYC(STRETCH_CYC), .EN_LOW_CYC(EN_LOW_CYC)) u_chk (.*);

/* File: gdfp_mcu_model.sv */
// motor controller model: enable, pwm and pulled-up open-drain lines
// assumes bench commands change right after a rising edge
`timescale 1ns/1ps
module gdfp_mcu_model (
  // clock and bench commands
  input wire clk,
  input wire en_cmd,
  input wire [5:0] pwm_cmd,
  // pins toward the driver
  output logic en_gate_pin = 1'b0,
  output logic [5:0] pwm_in = 6'h00,
  input wire fault_out_o, fault_out_oe_n, warning_out_pin_o, warning_out_pin_oe_n,
  // resolved pin levels
  output wire fault_n,
  output wire warn_n
);
  // low time chosen by the bench: short for quick reset, long to clear ov
  always @(posedge clk) begin
    en_gate_pin <= en_cmd;
    pwm_in <= en_cmd ? pwm_cmd : 6'h00;
  end
  assign fault_n = fault_out_oe_n ? 1'b1 : fault_out_o;
  assign warn_n = warning_out_pin_oe_n ? 1'b1 : warning_out_pin_o;
endmodule

/* File: testbench.sv */
// self-checking bench for the fault protection block
// assumes controller model and bound checker compiled first
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] rd = 32'h0;
  logic en_cmd = 1'b0;
  logic [5:0] pwm_cmd = 6'h00;
  logic [5:0] oc = 6'h00;
  // rail uv, drive uv, drive ov, logic uv, thermal warn, thermal shutdown
  logic [5:0] mon = 6'h00;
  wire [31:0] avs_readdata;
  wire [5:0] pwm_in, gate_out;
  wire avs_waitrequest, en_gate_pin, charge_pump_en, regulator_en, fault_n, warn_n;
  wire fault_out_o, fault_out_oe_n, warning_out_pin_o, warning_out_pin_oe_n;
  integer fail_count = 0;
  integer checks = 0;
  integer c0, c15;
  initial begin
    forever #50 clk = ~clk;
  end
  gdfp_top #(.STRETCH_CYC(16), .EN_LOW_CYC(8)) u_dut (.clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .en_gate_pin(en_gate_pin),
    .power_rail_undervoltage(mon[5]), .drive_supply_undervoltage(mon[4]),
    .drive_supply_overvoltage(mon[3]), .logic_supply_undervoltage(mon[2]),
    .thermal_warning(mon[1]), .thermal_shutdown_driver(mon[0]), .oc_detect(oc),
    .pwm_in(pwm_in), .gate_out(gate_out), .charge_pump_en(charge_pump_en),
    .regulator_en(regulator_en), .fault_out_o(fault_out_o), .fault_out_oe_n(fault_out_oe_n),
    .warning_out_pin_o(warning_out_pin_o), .warning_out_pin_oe_n(warning_out_pin_oe_n));
  gdfp_mcu_model u_mcu (.clk(clk), .en_cmd(en_cmd), .pwm_cmd(pwm_cmd),
    .en_gate_pin(en_gate_pin), .pwm_in(pwm_in), .fault_out_o(fault_out_o),
    .fault_out_oe_n(fault_out_oe_n), .warning_out_pin_o(warning_out_pin_o),
    .warning_out_pin_oe_n(warning_out_pin_oe_n), .fault_n(fault_n), .warn_n(warn_n));
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    begin
      checks = checks + 1;
      if (got !== e) begin
        $display("BAD %s expected %h seen %h", nm, e, got);
        fail_count = fail_count + 1;
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // avalon transfer held until waitrequest is sampled low
  task bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
    integer n;
    begin
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
        fail_count = fail_count + 1;
        give_verdict;
      end
    end
  endtask
  task st(input logic [1:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    begin
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd & m);
    end
  endtask
  task pins(input logic f, input logic w);
    begin
      chk("fault pin", {31'h0, f}, {31'h0, fault_n});
      chk("warning pin", {31'h0, w}, {31'h0, warn_n});
    end
  endtask
  task set_mon(input logic [5:0] v);
    begin
      @(posedge clk) mon <= v;
      cyc(6);
    end
  endtask
  task pulse(input logic [5:0] b);
    begin
      @(posedge clk) oc <= b;
      @(posedge clk) oc <= 6'h00;
      cyc(5);
    end
  endtask
  task toggle_en(input integer n);
    begin
      @(posedge clk) en_cmd <= 1'b0;
      repeat (n) @(posedge clk);
      en_cmd <= 1'b1;
      cyc(10);
    end
  endtask
  task dt_meas(output integer c);
    begin
      @(posedge clk) pwm_cmd <= 6'h10;
      cyc(10);
      @(posedge clk) pwm_cmd <= 6'h20;
      c = 0;
      while (gate_out[5] !== 1'b1 && c < 40) begin
        @(posedge clk);
        c = c + 1;
      end
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    en_cmd <= 1'b1;
    pwm_cmd <= 6'h20;
    cyc(12);
    bus(1'b0, 2'h0, 32'h0);
    bus(1'b0, 2'h1, 32'h0);
    pins(1'b1, 1'b1);
    chk("pump", 32'h1, {31'h0, charge_pump_en});
    $display("startup test done");
    bus(1'b1, 2'h2, 32'h20);
    pulse(6'h20);
    pins(1'b1, 1'b0);
    chk("gates", 32'h20, {26'h0, gate_out});
    cyc(7);
    pins(1'b1, 1'b0);
    cyc(12);
    pins(1'b1, 1'b1);
    st(2'h0, 32'h3f, 32'h20, "oc status");
    st(2'h0, 32'h3f, 32'h00, "second read");
    bus(1'b1, 2'h2, 32'h30);
    pulse(6'h04);
    pins(1'b1, 1'b1);
    st(2'h0, 32'h3f, 32'h00, "ignored oc");
    bus(1'b1, 2'h3, 32'h2);
    set_mon(6'h02);
    pins(1'b1, 1'b1);
    bus(1'b1, 2'h3, 32'h1);
    cyc(4);
    pins(1'b1, 1'b0);
    set_mon(6'h00);
    bus(1'b1, 2'h3, 32'h0);
    $display("overcurrent and warning tests done");
    bus(1'b1, 2'h2, 32'h10);
    pulse(6'h20);
    chk("phase off", 32'h0, {26'h0, gate_out & 6'h30});
    pins(1'b0, 1'b0);
    st(2'h0, 32'h420, 32'h420, "latched oc");
    toggle_en(3);
    pins(1'b1, 1'b1);
    chk("regulator kept", 32'h1, {31'h0, regulator_en});
    chk("gates back", 32'h20, {26'h0, gate_out});
    set_mon(6'h01);
    chk("ot gates", 32'h0, {26'h0, gate_out});
    set_mon(6'h00);
    chk("ot held", 32'h0, {31'h0, fault_n});
    st(2'h0, 32'h80, 32'h80, "ot status");
    st(2'h2, 32'h30, 32'h10, "settings kept");
    bus(1'b1, 2'h2, 32'h14);
    cyc(6);
    chk("reset cmd", 32'h1, {31'h0, fault_n});
    $display("latch and thermal tests done");
    set_mon(6'h08);
    set_mon(6'h00);
    chk("ov pump", 32'h0, {31'h0, charge_pump_en});
    bus(1'b1, 2'h2, 32'h14);
    toggle_en(3);
    chk("ov kept", 32'h0, {31'h0, fault_n});
    @(posedge clk) en_cmd <= 1'b0;
    cyc(14);
    chk("regulator off", 32'h0, {31'h0, regulator_en});
    @(posedge clk) en_cmd <= 1'b1;
    cyc(12);
    chk("ov cleared", 32'h1, {31'h0, fault_n});
    set_mon(6'h20);
    chk("uv fault", 32'h0, {31'h0, fault_n});
    set_mon(6'h00);
    st(2'h0, 32'h100, 32'h100, "uv status");
    set_mon(6'h04);
    chk("logic uv", 32'h0, {31'h0, fault_n});
    set_mon(6'h00);
    st(2'h0, 32'h7ff, 32'h0, "logic uv status");
    $display("supply tests done");
    dt_meas(c0);
    bus(1'b1, 2'h3, 32'hf0);
    dt_meas(c15);
    chk("dead time span", 32'h4, c15 - c0);
    @(posedge clk) pwm_cmd <= 6'h30;
    cyc(6);
    chk("both high", 32'h0, {26'h0, gate_out & 6'h30});
    bus(1'b1, 2'h2, 32'h0);
    @(posedge clk) pwm_cmd <= 6'h20;
    cyc(10);
    pulse(6'h20);
    chk("limited fet", 32'h0, {31'h0, gate_out[5]});
    pins(1'b1, 1'b0);
    st(2'h0, 32'h20, 32'h20, "limit bit");
    $display("dead time and limit tests done");
    give_verdict;
  end
endmodule
